/* File: design/pll_core_map.vh */
`ifndef PLL_CORE_MAP_VH
`define PLL_CORE_MAP_VH

// ----------------------------------------
// Serial link
// ----------------------------------------
`define ADDR_W 8
`define ADDR_IN 8'h82
`define ADDR_OUT 8'h92
`define WORD_W 32
`define FRAME_W 23
`define COUNT_W 20

// ----------------------------------------
// Input word fields
// ----------------------------------------
`define F_DIV_LSB 0
`define F_DIV_MSB 15
`define F_DIRECT_LSB 4
`define F_SPEED 16
`define F_FMSEL 17
`define F_RUN 18
`define F_REF_LSB 20
`define F_REF_MSB 23
`define F_GATE_LO 24
`define F_GATE_HI 25
`define F_DIR1 26
`define F_DIR2 27
`define F_OUT1 28
`define F_OUT2 29

// ----------------------------------------
// Divisor limits
// ----------------------------------------
`define SWALLOW_MIN 16'h0110
`define DIRECT_MIN 16'h0004

// ----------------------------------------
// Timing, clock in MHz, times in us
// ----------------------------------------
`define CLK_MHZ 40
`define GATE0_US 4000
`define GATE1_US 8000
`define GATE2_US 32000
`define GATE3_US 64000
`define WAIT_SHORT_US 3500
`define WAIT_LONG_US 7500
`define TIMER_W 24

// ----------------------------------------
// Wishbone registers
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COUNT 8'h08
`define REG_WORD 8'h0c
`define CTRL_RST 1'b1
`define S_RUN 0
`define S_DONE 1
`define S_UNLOCK 2
`define S_VALID 3

`endif

/* File: design/pll_divider_ifcount_readback.v */
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Port readback bits show actual pin levels, whatever the direction.
// - Pins captured on readback entry; high reads 1, low reads 0.
// - Lock bit reads 0 when unlocked, 1 when locked or detection off.
// - Frame carries 20-bit count snapshot, bit 19 most significant.
// - Count shifted out on data output, most significant bit first.
// - Data output is open-drain: pulls low for 0, releases for 1.
// - Serial clock may idle high or low; both work.
// - FM select 1: FM input, prescale by two, divisor 272..65535.
// - FM 0, speed 1: AM swallow mode, divisor 272..65535.
// - FM 0, speed 0: AM direct division, divisor 4..4095.
// - Gate select 00/01/10/11 gives 4/8/32/64 ms.
// - Wait 3-4 ms before short gates, 7-8 ms before long gates.
// - Counter accumulates input pulses during the gate.
// - Counter held cleared while run bit is 0; controller loads 0 first.
// - Count starts when run bit goes 0 to 1 in a latched word.
// - Input word latched on falling edge of chip enable strobe.
// - Unlock indication held until the next serial transfer.
`include "pll_core_map.vh"

module pll_divider_ifcount_readback #(
	parameter [`TIMER_W-1:0] GATE0_CYC = `GATE0_US * `CLK_MHZ,
	parameter [`TIMER_W-1:0] GATE1_CYC = `GATE1_US * `CLK_MHZ,
	parameter [`TIMER_W-1:0] GATE2_CYC = `GATE2_US * `CLK_MHZ,
	parameter [`TIMER_W-1:0] GATE3_CYC = `GATE3_US * `CLK_MHZ,
	parameter [`TIMER_W-1:0] WAITS_CYC = `WAIT_SHORT_US * `CLK_MHZ,
	parameter [`TIMER_W-1:0] WAITL_CYC = `WAIT_LONG_US * `CLK_MHZ
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire clk_en_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Serial link
	input wire frame_enable_i,
	input wire shift_strobe_pin_i,
	input wire serial_in_pin_i,
	output wire data_out_o,
	output wire data_out_oe_o,
	// Port pins
	input wire port1_pin_i,
	output wire port1_pin_o,
	output wire port1_pin_oe_o,
	input wire port2_pin_i,
	output wire port2_pin_o,
	output wire port2_pin_oe_o,
	// Synthesizer inputs
	input wire fm_prescaled_input_i,
	input wire am_divider_input_i,
	input wire if_input_pin_i,
	input wire unlock_detect_i,
	// Synthesizer outputs
	output reg divided_o,
	output reg divisor_valid_o,
	output wire [3:0] reference_select_bits_o
);

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_GATE = 2'h2;
	localparam ST_DONE = 2'h3;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Pulse inputs are sampled at the core clock, so each
	// must stay below half of it to be counted.
	reg [8:0] sync1_reg;
	reg [8:0] sync2_reg;
	reg [8:0] sync3_reg;
	wire [8:0] raw_in = {unlock_detect_i, port2_pin_i, port1_pin_i,
		if_input_pin_i, am_divider_input_i, fm_prescaled_input_i,
		serial_in_pin_i, shift_strobe_pin_i, frame_enable_i};

	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 9'h000;
			sync2_reg <= 9'h000;
			sync3_reg <= 9'h000;
		end else if (clk_en_i) begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	function rising;
		input [8:0] now;
		input [8:0] old;
		input [3:0] idx;
		begin
			rising = now[idx] & ~old[idx];
		end
	endfunction

	wire fe_lvl = sync2_reg[0];
	wire fe_rise = rising(sync2_reg, sync3_reg, 4'h0);
	wire fe_fall = rising(~sync2_reg, ~sync3_reg, 4'h0);
	wire cl_rise = rising(sync2_reg, sync3_reg, 4'h1);
	wire di_lvl = sync2_reg[2];
	wire fm_rise = rising(sync2_reg, sync3_reg, 4'h3);
	wire am_rise = rising(sync2_reg, sync3_reg, 4'h4);
	wire if_rise = rising(sync2_reg, sync3_reg, 4'h5);
	wire p1_lvl = sync2_reg[6];
	wire p2_lvl = sync2_reg[7];
	wire unlock_lvl = sync2_reg[8];

	// ----------------------------------------
	// Serial link
	// ----------------------------------------
	reg [`ADDR_W-1:0] addr_reg;
	reg [`WORD_W-1:0] shift_reg;
	reg [`WORD_W-1:0] word_reg;
	reg [`FRAME_W-1:0] frame_reg;
	reg in_mode_reg;
	reg out_mode_reg;
	reg unlock_seen_reg;
	reg detect_en_reg;
	reg [`COUNT_W-1:0] count_reg;
	wire lock_bit = ~(unlock_seen_reg & detect_en_reg);
	wire new_run = shift_reg[`F_RUN];
	wire start = fe_fall & in_mode_reg & new_run &
		~word_reg[`F_RUN];

	// Only rising strobe edges move data, so either idle level works
	always @(posedge clk_i) begin
		if (rst_i) begin
			addr_reg <= {`ADDR_W{1'b0}};
			shift_reg <= {`WORD_W{1'b0}};
			word_reg <= {`WORD_W{1'b0}};
			frame_reg <= {`FRAME_W{1'b1}};
			in_mode_reg <= 1'b0;
			out_mode_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (fe_rise) begin
				in_mode_reg <= (addr_reg == `ADDR_IN);
				out_mode_reg <= (addr_reg == `ADDR_OUT);
				// Snapshot taken at entry to readback
				frame_reg <= {p2_lvl, p1_lvl, lock_bit,
					count_reg};
			end else if (fe_fall) begin
				if (in_mode_reg)
					word_reg <= shift_reg;
				in_mode_reg <= 1'b0;
				out_mode_reg <= 1'b0;
			end else if (cl_rise) begin
				if (!fe_lvl)
					addr_reg <= {di_lvl, addr_reg[`ADDR_W-1:1]};
				else if (in_mode_reg)
					shift_reg <= {di_lvl, shift_reg[`WORD_W-1:1]};
				else if (out_mode_reg)
					frame_reg <= {frame_reg[`FRAME_W-2:0],
						1'b1};
			end
		end
	end

	// Never drive high; pull-up makes the 1s
	assign data_out_o = 1'b0;
	assign data_out_oe_o = out_mode_reg & fe_lvl &
		~frame_reg[`FRAME_W-1];

	assign port1_pin_o = word_reg[`F_OUT1];
	assign port1_pin_oe_o = word_reg[`F_DIR1];
	assign port2_pin_o = word_reg[`F_OUT2];
	assign port2_pin_oe_o = word_reg[`F_DIR2];
	assign reference_select_bits_o = word_reg[`F_REF_MSB:`F_REF_LSB];

	// ----------------------------------------
	// Unlock memory
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i)
			unlock_seen_reg <= 1'b0;
		else if (clk_en_i) begin
			if (unlock_lvl)
				unlock_seen_reg <= 1'b1;
			else if (fe_fall)
				unlock_seen_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Programmable divider
	// ----------------------------------------
	reg [15:0] div_cnt_reg;
	reg prescale_reg;
	wire fm_mode = word_reg[`F_FMSEL];
	wire direct_mode = ~fm_mode & ~word_reg[`F_SPEED];
	wire [15:0] set_div = word_reg[`F_DIV_MSB:`F_DIV_LSB];
	wire [15:0] ratio = direct_mode ?
		{4'h0, set_div[15:`F_DIRECT_LSB]} : set_div;
	wire div_ok = direct_mode ? (ratio >= `DIRECT_MIN) :
		(ratio >= `SWALLOW_MIN);
	// FM edges pass a divide-by-two first, doubling the ratio
	wire div_tick = fm_mode ? (fm_rise & prescale_reg) :
		am_rise;

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 16'h0000;
			prescale_reg <= 1'b0;
			divided_o <= 1'b0;
			divisor_valid_o <= 1'b0;
		end else if (clk_en_i) begin
			divisor_valid_o <= div_ok;
			divided_o <= 1'b0;
			if (fm_rise)
				prescale_reg <= ~prescale_reg;
			if (!div_ok)
				div_cnt_reg <= 16'h0000;
			else if (div_tick) begin
				if (div_cnt_reg >= ratio - 16'h0001) begin
					div_cnt_reg <= 16'h0000;
					divided_o <= 1'b1;
				end else
					div_cnt_reg <= div_cnt_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// IF counter
	// ----------------------------------------
	reg [1:0] state_reg;
	reg [`TIMER_W-1:0] timer_reg;
	wire [1:0] gate_sel = {word_reg[`F_GATE_HI], word_reg[`F_GATE_LO]};
	reg [`TIMER_W-1:0] gate_cyc;
	wire [`TIMER_W-1:0] wait_cyc = gate_sel[1] ? WAITL_CYC :
		WAITS_CYC;

	always @* begin
		case (gate_sel)
		2'h0: gate_cyc = GATE0_CYC;
		2'h1: gate_cyc = GATE1_CYC;
		2'h2: gate_cyc = GATE2_CYC;
		default: gate_cyc = GATE3_CYC;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			timer_reg <= {`TIMER_W{1'b0}};
			count_reg <= {`COUNT_W{1'b0}};
		end else if (clk_en_i) begin
			if (start) begin
				state_reg <= ST_WAIT;
				timer_reg <= {`TIMER_W{1'b0}};
				count_reg <= {`COUNT_W{1'b0}};
			end else if (!word_reg[`F_RUN]) begin
				state_reg <= ST_IDLE;
				count_reg <= {`COUNT_W{1'b0}};
			end else begin
				case (state_reg)
				ST_WAIT: begin
					if (timer_reg >= wait_cyc - 1'b1) begin
						state_reg <= ST_GATE;
						timer_reg <= {`TIMER_W{1'b0}};
					end else
						timer_reg <= timer_reg + 1'b1;
				end
				ST_GATE: begin
					if (if_rise)
						count_reg <= count_reg + 1'b1;
					if (timer_reg >= gate_cyc - 1'b1)
						state_reg <= ST_DONE;
					else
						timer_reg <= timer_reg + 1'b1;
				end
				default: state_reg <= state_reg;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	// Ack one cycle after the request; unmapped reads return zero
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	reg [31:0] rd_data;

	always @* begin
		case (wb_adr_i)
		`REG_CTRL: rd_data = {31'h0, detect_en_reg};
		`REG_STATUS: rd_data = {28'h0, divisor_valid_o,
			unlock_seen_reg, state_reg == ST_DONE,
			state_reg != ST_IDLE};
		`REG_COUNT: rd_data = {12'h000, count_reg};
		`REG_WORD: rd_data = word_reg;
		default: rd_data = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			detect_en_reg <= `CTRL_RST;
		end else if (clk_en_i) begin
			wb_ack_o <= wb_req;
			if (wb_req) begin
				wb_dat_o <= rd_data;
				if (wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL)
					detect_en_reg <= wb_dat_i[0];
			end
		end
	end

endmodule // pll_divider_ifcount_readback

/* File: verif/pll_chk_sva.sv */
`timescale 1ns/1ps
module pll_chk (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Watched pins
	input wire frame_enable_i,
	input wire data_out_o,
	input wire data_out_oe_o,
	input wire port1_pin_o,
	input wire port1_pin_oe_o,
	input wire port2_pin_o,
	input wire port2_pin_oe_o,
	input wire divided_o,
	input wire divisor_valid_o,
	input wire [3:0] reference_select_bits_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_DO_LOW: assert property (data_out_o == 1'b0)
		else $error("data pin driven high");
	AST_DO_REL: assert property (!frame_enable_i [*6] |-> !data_out_oe_o)
		else $error("data line held after frame");
	AST_P1_LATCH: assert property ($changed({port1_pin_o, port1_pin_oe_o})
		|-> !frame_enable_i) else $error("port 1 changed in frame");
	AST_P2_LATCH: assert property ($changed({port2_pin_o, port2_pin_oe_o})
		|-> !frame_enable_i) else $error("port 2 changed in frame");
	AST_REF_LATCH: assert property ($changed(reference_select_bits_o)
		|-> !frame_enable_i) else $error("ref bits changed in frame");
	AST_VALID_LATCH: assert property ($changed(divisor_valid_o)
		|-> !frame_enable_i) else $error("valid changed in frame");
	AST_DIV_GAP: assert property (divided_o |=> !divided_o [*8])
		else $error("divider pulses too close");
	AST_DIV_RANGE: assert property (divided_o
		|-> divisor_valid_o || $past(divisor_valid_o))
		else $error("divider pulse with bad divisor");
endmodule // pll_chk
bind pll_divider_ifcount_readback pll_chk i_chk (.clk_i, .rst_i,
	.frame_enable_i, .data_out_o, .data_out_oe_o, .port1_pin_o,
	.port1_pin_oe_o, .port2_pin_o, .port2_pin_oe_o, .divided_o,
	.divisor_valid_o, .reference_select_bits_o);

/* File: verif/link_ctrl.sv */
`timescale 1ns/1ps
`include "pll_core_map.vh"
module link_ctrl (
	input wire clk_i,
	input wire do_i,
	output logic en_o,
	output logic scl_o,
	output logic sd_o
);
	logic idle_hi = 1'b0;
	initial begin
		en_o = 1'b0;
		scl_o = 1'b0;
		sd_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic bit_out(input logic b);
		scl_o <= 1'b0;
		sd_o <= b;
		tick(4);
		scl_o <= 1'b1;
		tick(4);
	endtask
	task automatic frame(input logic rd, input logic [31:0] w,
		output logic [22:0] r);
		logic [7:0] a;
		a = rd ? `ADDR_OUT : `ADDR_IN;
		r = 23'h0;
		@(posedge clk_i);
		for (int i = 0; i < 8; i++)
			bit_out(a[i]);
		en_o <= 1'b1;
		tick(8);
		for (int i = 0; i < 32 && !rd; i++)
			bit_out(w[i]);
		for (int i = 0; i < 23 && rd; i++) begin
			scl_o <= 1'b0;
			tick(4);
			// Read just before the rising edge
			r = {r[21:0], do_i};
			scl_o <= 1'b1;
			tick(4);
		end
		scl_o <= idle_hi;
		en_o <= 1'b0;
		// Released line must not keep the last bit
		sd_o <= ~sd_o;
		tick(12);
	endtask
endmodule // link_ctrl

/* File: verif/tb.sv */
`timescale 1ns/1ps
`include "pll_core_map.vh"
module tb;
	// Short gate and wait lengths keep the run brief
	localparam logic [23:0] T_G0 = 24'd40;
	localparam logic [23:0] T_G1 = 24'd80;
	localparam logic [23:0] T_G2 = 24'd320;
	localparam logic [23:0] T_G3 = 24'd640;
	localparam logic [23:0] T_WS = 24'd30;
	localparam logic [23:0] T_WL = 24'd70;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic clk_en = 1'b1;
	logic [3:0] sel = 4'hf;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q;
	logic [22:0] r;
	logic p1_ext = 1'b0;
	logic p2_ext = 1'b0;
	logic unl = 1'b0;
	logic [3:0] ph = 4'h0;
	wire [31:0] rdat;
	wire [3:0] refs;
	wire do_pin;
	wire ack, do_oe, p1_o, p1_oe, p2_o, p2_oe, div, dval, en, scl, sd;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) ph <= ph + 4'h1;
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_fail++;
			wrap_up();
		end
	end
	pll_divider_ifcount_readback #(.GATE0_CYC(T_G0), .GATE1_CYC(T_G1),
		.GATE2_CYC(T_G2), .GATE3_CYC(T_G3), .WAITS_CYC(T_WS),
		.WAITL_CYC(T_WL)) i_dut (.clk_i, .rst_i, .clk_en_i(clk_en),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.frame_enable_i(en), .shift_strobe_pin_i(scl), .serial_in_pin_i(sd),
		.data_out_o(do_pin), .data_out_oe_o(do_oe),
		.port1_pin_i(p1_oe ? p1_o : p1_ext), .port1_pin_o(p1_o),
		.port1_pin_oe_o(p1_oe), .port2_pin_i(p2_oe ? p2_o : p2_ext),
		.port2_pin_o(p2_o), .port2_pin_oe_o(p2_oe),
		.fm_prescaled_input_i(ph[3]), .am_divider_input_i(ph[3]),
		.if_input_pin_i(ph[2]), .unlock_detect_i(unl), .divided_o(div),
		.divisor_valid_o(dval), .reference_select_bits_o(refs));
	// Open drain line: the pull-up gives 1 whenever the pin is released
	link_ctrl i_link (.clk_i, .do_i(do_oe ? do_pin : 1'b1), .en_o(en),
		.scl_o(scl), .sd_o(sd));
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	function automatic logic [31:0] wd(input logic [3:0] io,
		input logic [1:0] gt, input logic run, input logic [17:0] md);
		return {2'b00, io, gt, 4'h5, 1'b0, run, md};
	endfunction
	task automatic t_lock();
		wb(1'b0, `REG_CTRL, 32'h0);
		chk("ctrl", q, 32'h1);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", q, 32'h0);
		unl <= 1'b1;
		wb(1'b1, `REG_CTRL, 32'h0);
		i_link.frame(1'b1, 32'h0, r);
		chk("lock off", r[20], 1'b1);
		wb(1'b1, `REG_CTRL, 32'h1);
		i_link.frame(1'b1, 32'h0, r);
		chk("unlocked", r[20], 1'b0);
		unl <= 1'b0;
		i_link.idle_hi = 1'b1;
		i_link.frame(1'b1, 32'h0, r);
		chk("sticky", r[20], 1'b0);
		i_link.frame(1'b1, 32'h0, r);
		chk("relock", r[20], 1'b1);
		i_link.idle_hi = 1'b0;
		$display("lock test done");
	endtask
	task automatic t_count();
		int gate [4] = '{T_G0, T_G1, T_G2, T_G3};
		int n;
		for (int k = 0; k < 4; k++) begin
			p1_ext <= (k == 2);
			p2_ext <= k[0];
			// Count enable cleared first
			i_link.frame(1'b0, wd({2'b00, k[1:0] == 3 ? 2'b11 : 2'b00}, k[1:0],
				1'b0, 18'h0), r);
			wb(1'b0, `REG_COUNT, 32'h0);
			chk("cleared", q, 32'h0);
			chk("ref", refs, 4'h5);
			// IF input runs all the time, so station detect stands
			i_link.frame(1'b0, wd(k == 3 ? 4'h5 : 4'h0, k[1:0], 1'b1, 18'h0),
				r);
			wb(1'b0, `REG_COUNT, 32'h0);
			chk("in wait", q, 32'h0);
			n = 0;
			do wb(1'b0, `REG_STATUS, 32'h0);
			while (q[`S_DONE] !== 1'b1 && ++n < 400);
			chk("done", q[`S_DONE], 1'b1);
			i_link.frame(1'b1, 32'h0, r);
			chk("count", r[19:0], gate[k] / 8);
			chk("ports", r[22:20], {k[0], k >= 2, 1'b1});
		end
		$display("count test done");
	endtask
	task automatic t_div();
		logic [17:0] cfg [5] = '{18'h0004f, 18'h00030, 18'h10110, 18'h1010f,
			18'h30110};
		int len [5] = '{32, 32, 272, 32, 544};
		int exp [5] = '{8, 0, 1, 0, 1};
		int n;
		for (int k = 0; k < 5; k++) begin
			i_link.frame(1'b0, wd(4'h0, 2'b00, 1'b0, cfg[k]), r);
			chk("valid", dval, exp[k] != 0);
			for (int p = 0; p < 2; p++) begin
				n = 0;
				while (ph !== 4'h0)
					@(posedge clk_i);
				repeat (len[k] * 16) begin
					@(posedge clk_i);
					n += div;
				end
			end
			chk("pulses", n, exp[k]);
			// Lock looked at only after the divider has settled
			i_link.frame(1'b1, 32'h0, r);
			chk("lock", r[20], 1'b1);
		end
		$display("divider test done");
	endtask
	task automatic t_freeze();
		@(posedge clk_i);
		clk_en <= 1'b0;
		cyc <= 1'b1;
		we <= 1'b0;
		adr <= `REG_WORD;
		repeat (8) @(posedge clk_i);
		chk("frozen ack", ack, 1'b0);
		clk_en <= 1'b1;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		chk("word", q, wd(4'h5, 2'b11, 1'b1, 18'h0));
		// A write without its byte lane must be dropped
		sel <= 4'he;
		wb(1'b1, `REG_CTRL, 32'h0);
		sel <= 4'hf;
		wb(1'b0, `REG_CTRL, 32'h0);
		chk("sel", q, 32'h1);
		$display("freeze test done");
	endtask
	task automatic wrap_up();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_lock();
		t_count();
		t_freeze();
		t_div();
		wrap_up();
	end
endmodule // tb
